// ==== dv/gli_board.sv ====
// Board model: pull-ups on the three pins, an external driver, the strap.
// Assumes the block's enables are high while it drives a pin.
`timescale 1ns/10ps
module gli_board (
    // Block side
    input  wire logic [2:0] gpio_out,
    input  wire logic [2:0] gpio_oe,
    output logic      [2:0] gpio_in,
    output logic            crossover_strap_en,
    // Bench control
    input  wire logic [2:0] ext_oe,
    input  wire logic [2:0] ext_val,
    input  wire logic       strap_low
);
    // Wire level: block, else board driver, else pull-up
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            gpio_in[i] = gpio_oe[i] ? gpio_out[i] : (ext_oe[i] ? ext_val[i] : 1'b1);
        end
    end
    // Floating strap reads high
    assign crossover_strap_en = !strap_low;
endmodule : gli_board

// ==== dv/gli_gpio_led_monitor.sv ====
// Assertions on the GPIO / status LED block ports.
// Assumes LED enables settle seven cycles after any register write.
`timescale 1ns/10ps
module gli_gpio_led_monitor #(
    parameter int ACT_PULSE_CYC = 8
) (
    // Clock, reset, register port
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire logic [7:0]        reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    // Status, strap, pins
    input wire gli_pkg::gli_link_t link_st,
    input wire logic              tx_act,
    input wire logic              rx_act,
    input wire logic              crossover_strap_en,
    input wire logic              crossover_en,
    input wire logic [2:0]        gpio_in,
    input wire logic [2:0]        gpio_out,
    input wire logic [2:0]        gpio_oe
);
    import gli_pkg::*;
    logic [2:0]  led_r;
    logic [2:0]  quiet_r;
    logic [15:0] off_r;
    logic [15:0] on_r;
    logic        ok;
    assign ok = quiet_r == 3'h7;
    // LED enables, settle time, indicator phase lengths
    always_ff @(posedge ref_clk)
    begin
        if (rst || reg_wr)
        begin
            quiet_r <= 3'h0;
            off_r   <= 16'h0000;
            on_r    <= 16'h0000;
        end
        else
        begin
            quiet_r <= ok ? quiet_r : quiet_r + 3'h1;
            off_r   <= (gpio_oe[1] || !link_st.link_up || !led_r[1]) ? 16'h0000 : off_r + 16'h1;
            on_r    <= !gpio_oe[1] ? 16'h0000 : on_r + {15'h0, on_r != 16'hffff};
        end
        if (rst)
            led_r <= 3'h7;
        else if (reg_wr && reg_addr == GLI_CFG_OFS)
            led_r <= reg_wdata[10:8];
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_link_steady;
        $stable(link_st)[*3];
    endsequence
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside read slot");
    a_led_open_drain: assert property (ok |-> (gpio_out & led_r) == 3'h0)
        else $error("LED pin driven high");
    a_speed_ind: assert property (s_link_steady ##0 (ok && led_r[0]) |->
        gpio_oe[0] == (link_st.link_up && link_st.speed_100 && !link_st.autoneg_busy))
        else $error("speed indicator wrong");
    a_duplex_ind: assert property (s_link_steady ##0 (ok && led_r[2]) |->
        gpio_oe[2] == (link_st.link_up && link_st.full_duplex))
        else $error("duplex indicator wrong");
    a_link_down: assert property (
        s_link_steady ##0 (ok && led_r[1] && !link_st.link_up) |-> !gpio_oe[1])
        else $error("link indicator lit without link");
    a_blink_len: assert property (
        $rose(gpio_oe[1]) && off_r > 16'h0003 |-> off_r == ACT_PULSE_CYC)
        else $error("activity off pulse length wrong");
    a_blink_hold: assert property (
        $fell(gpio_oe[1]) && link_st.link_up && ok && led_r[1] |-> on_r >= ACT_PULSE_CYC)
        else $error("activity on hold too short");
    a_strap_capture: assert property ($fell(rst) |-> ##1 crossover_en == $past(crossover_strap_en))
        else $error("strap not captured");
    a_strap_hold: assert property (!$past(rst) && !$past(rst, 2) |-> $stable(crossover_en))
        else $error("crossover enable changed");
endmodule : gli_gpio_led_monitor

bind gli_gpio_led gli_gpio_led_monitor #(.ACT_PULSE_CYC(ACT_PULSE_CYC)) gli_gpio_led_monitor_i (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_st(link_st),
    .tx_act(tx_act), .rx_act(rx_act), .crossover_strap_en(crossover_strap_en),
    .crossover_en(crossover_en), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe)
);

// ==== dv/tb_top.sv ====
// Self-checking bench for the GPIO / status LED block.
// Assumes 10 MHz clock and an activity pulse shortened to 8 cycles.
`timescale 1ns/10ps
module tb_top;
    import gli_pkg::*;
    localparam int P = 8;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    gli_link_t   link_st = 4'h0;
    logic        tx_act = 1'b0;
    logic        rx_act = 1'b0;
    logic        strap_en;
    logic        crossover_en;
    logic [2:0]  gpio_in;
    logic [2:0]  gpio_out;
    logic [2:0]  gpio_oe;
    logic [2:0]  ext_oe = 3'h0;
    logic [2:0]  ext_val = 3'h0;
    logic        strap_low = 1'b0;
    int          failures = 0;
    int          num_checks = 0;
    int          n;
    gli_gpio_led #(.ACT_PULSE_CYC(P)) gli_gpio_led_i (.ref_clk(ref_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .link_st(link_st), .tx_act(tx_act), .rx_act(rx_act),
        .crossover_strap_en(strap_en), .crossover_en(crossover_en), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe));
    gli_board gli_board_i (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
        .crossover_strap_en(strap_en), .ext_oe(ext_oe), .ext_val(ext_val), .strap_low(strap_low));
    initial
    begin
        forever #50 ref_clk = ~ref_clk;
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic summarize();
        $display("Checks %0d, failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
            $display("Error %0t: got %h expected %h", $time, got, exp);
        if (got !== exp)
            failures++;
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata & m, e);
    endtask : rd
    // Cycles the link indicator holds enable level v
    task automatic span(input logic v, output int c);
        c = 0;
        while (gpio_oe[1] === v && c < 50)
        begin
            @(posedge ref_clk);
            #1;
            c++;
        end
        if (c == 50)
        begin
            failures++;
            $display("Error %0t: indicator stuck", $time);
            summarize();
        end
    endtask : span
    function automatic logic [2:0] led_oe(input gli_link_t s);
        return {s.link_up & s.full_duplex, s.link_up, s.link_up & s.speed_100 & ~s.autoneg_busy};
    endfunction : led_oe
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        gli_link_t tbl [4] = '{4'b1101, 4'b1000, 4'b1111, 4'b0101};
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd(GLI_CFG_OFS, 32'hffff_ffff, 32'h0000_0700);
        rd(GLI_DATA_OFS, 32'hffff_ffff, 32'h0000_0000);
        rd(8'h0c, 32'hffff_ffff, 32'h0000_0000);
        chk({31'h0, crossover_en}, 32'h0000_0001);
        $display("Test reset done");
        foreach (tbl[i])
        begin
            link_st <= tbl[i];
            repeat (5) @(posedge ref_clk);
            #1;
            chk({29'h0, gpio_oe}, {29'h0, led_oe(tbl[i])});
            rd(GLI_STAT_OFS, 32'h0000_007f, {25'h0, ~led_oe(tbl[i]), 1'b1, ~led_oe(tbl[i])});
        end
        $display("Test indicators done");
        @(posedge ref_clk);
        link_st <= 4'b1101;
        repeat (20) @(posedge ref_clk);
        tx_act <= 1'b1;
        @(posedge ref_clk);
        tx_act <= 1'b0;
        rx_act <= 1'b1;
        #1;
        span(1'b1, n);
        span(1'b0, n);
        chk(n, P);
        span(1'b1, n);
        chk(n, P);
        span(1'b0, n);
        chk(n, P);
        @(posedge ref_clk);
        rx_act <= 1'b0;
        repeat (4 * P) @(posedge ref_clk);
        #1;
        chk({31'h0, gpio_oe[1]}, 32'h0000_0001);
        $display("Test activity done");
        @(posedge ref_clk);
        link_st <= 4'b0000;
        ext_oe  <= 3'b100;
        wr(GLI_CFG_OFS, 32'h0000_0009);
        wr(GLI_DATA_OFS, 32'h0000_0007);
        // Let the pins and the sampled pin levels settle before reading
        repeat (2) @(posedge ref_clk);
        rd(GLI_STAT_OFS, 32'h0000_0007, 32'h0000_0003);
        chk({29'h0, gpio_oe}, 32'h0000_0001);
        @(posedge ref_clk);
        ext_val <= 3'b100;
        wr(GLI_DATA_OFS, 32'h0000_0000);
        wr(GLI_STAT_OFS, 32'h0000_00ff);
        rd(GLI_STAT_OFS, 32'h0000_0007, 32'h0000_0004);
        chk({29'h0, gpio_oe}, 32'h0000_0003);
        rd(GLI_CFG_OFS, 32'hffff_ffff, 32'h0000_0009);
        $display("Test pin modes done");
        @(posedge ref_clk);
        strap_low <= 1'b1;
        rst       <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk({31'h0, crossover_en}, 32'h0000_0000);
        rd(GLI_CFG_OFS, 32'hffff_ffff, 32'h0000_0700);
        $display("Test strap done");
        summarize();
    end
endmodule : tb_top

// ==== src/gli_act_blink.sv ====
// Activity blink timer for the link/activity indicator.
// Assumes activity is a synchronous level or pulse on ref_clk.
`timescale 1ns/10ps
module gli_act_blink #(
    parameter int PULSE_CYC = gli_pkg::ACT_PULSE_CYC
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Status in
    input  wire logic link_up,
    input  wire logic activity,
    // Indicator off request
    output logic      off_r
);
    import gli_pkg::*;

    typedef struct packed {
        gli_act_st_t           st;
        logic [ACT_CNT_W-1:0]  cnt;
        logic                  seen;
        logic                  off;
    } gli_blink_t;

    localparam logic [ACT_CNT_W-1:0] LAST = ACT_CNT_W'(PULSE_CYC - 1);

    gli_blink_t s_r;
    gli_blink_t s_nxt;

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.cnt = s_r.cnt + 1'b1;
        case (s_r.st)
            ACT_ON:
            begin
                s_nxt.cnt = '0;
                if (activity)
                begin
                    s_nxt.st  = ACT_OFF;
                    s_nxt.off = 1'b1;
                end
            end
            ACT_OFF:
            begin
                if (s_r.cnt == LAST)
                begin
                    s_nxt.st   = ACT_HOLD;
                    s_nxt.cnt  = '0;
                    s_nxt.off  = 1'b0;
                    s_nxt.seen = 1'b0;
                end
            end
            ACT_HOLD:
            begin
                if (activity)
                    s_nxt.seen = 1'b1;
                if (s_r.cnt == LAST)
                begin
                    s_nxt.cnt = '0;
                    if (s_r.seen || activity)
                    begin
                        s_nxt.st  = ACT_OFF;
                        s_nxt.off = 1'b1;
                    end
                    else
                        s_nxt.st = ACT_ON;
                end
            end
            default:
            begin
                s_nxt.st  = ACT_ON;
                s_nxt.off = 1'b0;
            end
        endcase
        // No blinking without a link
        if (!link_up)
        begin
            s_nxt.st   = ACT_ON;
            s_nxt.cnt  = '0;
            s_nxt.off  = 1'b0;
            s_nxt.seen = 1'b0;
        end
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            s_r <= '{st: ACT_ON, cnt: '0, seen: 1'b0, off: 1'b0};
        else
            s_r <= s_nxt;
    end

    assign off_r = s_r.off;

endmodule : gli_act_blink

// ==== src/gli_gpio_led.sv ====
// GPIO pins shared with open-drain link status indicators, plus crossover strap.
// Assumes link status inputs are synchronous to ref_clk; pin wire resolved outside.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module gli_gpio_led #(
    parameter int ACT_PULSE_CYC = gli_pkg::ACT_PULSE_CYC
) (
    // Clock and reset
    input  wire logic            ref_clk,
    input  wire logic            rst,
    // Register port
    input  wire logic [7:0]      reg_addr,
    input  wire logic [31:0]     reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic      [31:0]     reg_rdata,
    // Internal link status
    input  wire gli_pkg::gli_link_t link_st,
    input  wire logic            tx_act,
    input  wire logic            rx_act,
    // Strap
    input  wire logic            crossover_strap_en,
    output logic                 crossover_en,
    // General-purpose pins
    input  wire logic [2:0]      gpio_in,
    output logic      [2:0]      gpio_out,
    output logic      [2:0]      gpio_oe
);
    import gli_pkg::*;

    typedef struct packed {
        logic [5:0]  mode;
        logic [2:0]  led_en;
        logic [2:0]  dout;
        logic [31:0] rdata;
        gli_pins_t   pins;
        logic        xovr;
        logic        strap_taken;
        logic [2:0]  ind_n;    // duplex, link/act, speed
        logic [2:0]  pin_lvl;
    } gli_state_t;

    gli_state_t s_r;
    gli_state_t s_nxt;
    logic       act_off;
    logic       speed_ind_n;
    logic       link_act_ind_n;
    logic       duplex_ind_n;

    // --------------------------------------------------------------
    // Pin drive for one pin: returns {out, oe}
    // --------------------------------------------------------------
    function automatic logic [1:0] pin_drive(
        input logic       led,
        input logic       ind_n,
        input logic [1:0] mode,
        input logic       dout
    );
        logic [1:0] r;
        r = 2'b00;
        if (led)
            r = {1'b0, ~ind_n};
        else if (mode == MODE_IN)
            r = 2'b00;
        else if (mode == MODE_PP)
            r = {dout, 1'b1};
        else
            r = {1'b0, ~dout};
        return r;
    endfunction : pin_drive

    // --------------------------------------------------------------
    // Activity blink timer
    // --------------------------------------------------------------
    gli_act_blink #(
        .PULSE_CYC (ACT_PULSE_CYC)
    ) u_blink (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .link_up   (link_st.link_up),
        .activity  (tx_act | rx_act),
        .off_r     (act_off)
    );

    // --------------------------------------------------------------
    // Indicator levels
    // --------------------------------------------------------------
    assign speed_ind_n    = ~(link_st.link_up & link_st.speed_100
                              & ~link_st.autoneg_busy);
    assign link_act_ind_n = ~link_st.link_up | act_off;
    assign duplex_ind_n   = ~(link_st.link_up & link_st.full_duplex);

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb
    begin
        logic [1:0] d;
        d = 2'b00;
        s_nxt = s_r;
        s_nxt.rdata   = '0;
        s_nxt.pin_lvl = gpio_in;
        s_nxt.ind_n   = {duplex_ind_n, link_act_ind_n, speed_ind_n};
        // Strap taken once after reset release
        if (!s_r.strap_taken)
        begin
            s_nxt.xovr        = crossover_strap_en;
            s_nxt.strap_taken = 1'b1;
        end
        // Register writes
        if (reg_wr)
        begin
            case (reg_addr)
                GLI_CFG_OFS:
                begin
                    s_nxt.mode   = reg_wdata[CFG_MODE_LSB +: 6];
                    s_nxt.led_en = reg_wdata[CFG_LED_LSB +: 3];
                end
                GLI_DATA_OFS: s_nxt.dout = reg_wdata[2:0];
                default:      s_nxt.dout = s_r.dout;
            endcase
        end
        // Register reads, data in next cycle only
        if (reg_rd)
        begin
            case (reg_addr)
                GLI_CFG_OFS:
                begin
                    s_nxt.rdata[CFG_MODE_LSB +: 6] = s_r.mode;
                    s_nxt.rdata[CFG_LED_LSB +: 3]  = s_r.led_en;
                end
                GLI_DATA_OFS: s_nxt.rdata[2:0] = s_r.dout;
                GLI_STAT_OFS:
                begin
                    s_nxt.rdata[STAT_PIN_LSB +: 3] = s_r.pin_lvl;
                    s_nxt.rdata[STAT_XOVR_BIT]     = s_r.xovr;
                    s_nxt.rdata[STAT_IND_LSB +: 3] = s_r.ind_n;
                end
                default:      s_nxt.rdata = '0;
            endcase
        end
        // Pin drivers
        for (int i = 0; i < 3; i++)
        begin
            d = pin_drive(s_r.led_en[i], s_r.ind_n[i], s_r.mode[2*i +: 2], s_r.dout[i]);
            s_nxt.pins.out[i] = d[1];
            s_nxt.pins.oe[i]  = d[0];
        end
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_r             <= '0;
            s_r.mode        <= CFG_MODE_RST;
            s_r.led_en      <= CFG_LED_RST;
            s_r.dout        <= DATA_RST;
            s_r.ind_n       <= 3'h7;
            s_r.xovr        <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    // Outputs straight from flops
    assign reg_rdata    = s_r.rdata;
    assign crossover_en = s_r.xovr;
    assign gpio_out     = s_r.pins.out;
    assign gpio_oe      = s_r.pins.oe;

endmodule : gli_gpio_led

// ==== src/gli_pkg.sv ====
// Constants, carriers and register map for the GPIO / status LED block.
// Assumes one 10 MHz clock and a synchronous active-high reset.
//
// How it works
// - Crossover enabled unless strap held low
// - Each pin: push-pull, open-drain or input
// - LED function drives pins open-drain only
// - Speed indicator low at 100 Mb/s
// - Speed indicator high otherwise, incl. negotiation
// - Link/activity indicator low while link valid
// - Activity turns indicator off for 80 ms
// - Then on at least 80 ms before next
// - Duplex indicator low in full duplex
// - Everything runs on the reference clock
// - Reset returns all state to defaults
package gli_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_KHZ        = 10_000;                 // 100 ns period
    localparam int ACT_PULSE_MS   = 80;
    localparam int ACT_PULSE_CYC  = ACT_PULSE_MS * CLK_KHZ;
    localparam int ACT_CNT_W      = 20;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] GLI_CFG_OFS  = 8'h00;
    localparam logic [7:0] GLI_DATA_OFS = 8'h04;
    localparam logic [7:0] GLI_STAT_OFS = 8'h08;

    // Field positions
    localparam int CFG_MODE_LSB  = 0;   // 2 bits per pin, pins 0..2
    localparam int CFG_LED_LSB   = 8;   // 1 bit per pin
    localparam int STAT_PIN_LSB  = 0;
    localparam int STAT_XOVR_BIT = 3;
    localparam int STAT_IND_LSB  = 4;

    // Reset values
    localparam logic [5:0] CFG_MODE_RST = 6'h00;
    localparam logic [2:0] CFG_LED_RST  = 3'h7;
    localparam logic [2:0] DATA_RST     = 3'h0;

    // Pin modes
    localparam logic [1:0] MODE_IN = 2'h0;
    localparam logic [1:0] MODE_PP = 2'h1;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic link_up;
        logic speed_100;
        logic autoneg_busy;
        logic full_duplex;
    } gli_link_t;

    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe;
    } gli_pins_t;

    typedef enum logic [1:0] {
        ACT_ON,
        ACT_OFF,
        ACT_HOLD
    } gli_act_st_t;

endpackage : gli_pkg
